// >>> ahp_pkg.sv
// constants for the parallel host command port
package ahp_pkg;
   localparam int CLK_PERIOD_NS = 4;
   localparam int CFG_W = 13;
   localparam logic [12:0] CFG_RESET = 13'h0100;
   localparam int MUX_LSB = 0;
   localparam int MUX_W = 4;
   localparam int ACQ_LSB = 4;
   localparam int SE_BIT = 6;
   localparam int HB_BIT = 7;
   localparam int SYNC_BIT = 8;
   localparam int CMD_LSB = 9;
   localparam int BW_BIT = 12;
   localparam logic [2:0] CMD_NORMAL = 3'h0;
   localparam logic [2:0] CMD_AUTOCAL = 3'h1;
   localparam logic [2:0] CMD_AUTOZERO = 3'h2;
   localparam logic [2:0] CMD_RESET = 3'h3;
   localparam logic [2:0] CMD_STANDBY = 3'h4;
   localparam logic [2:0] CMD_TEST_A = 3'h5;
   localparam logic [2:0] CMD_TEST_B = 3'h6;
   localparam int WR_RDY_NS = 65;
   localparam int RD_RDY_NS = 38;
   localparam int STBY_NS = 230;
   localparam int WAKE_NS = 45;
   localparam int WAKE_RDY_US = 2500;
   localparam int WR_RDY_CYC = WR_RDY_NS / CLK_PERIOD_NS;
   localparam int RD_RDY_CYC = RD_RDY_NS / CLK_PERIOD_NS;
   localparam int STBY_CYC = STBY_NS / CLK_PERIOD_NS;
   localparam int WAKE_CYC = WAKE_NS / CLK_PERIOD_NS;
   localparam int WAKE_RDY_CYC = WAKE_RDY_US * 1000 / CLK_PERIOD_NS;
   localparam int CONV_CYC = 44;
   localparam int CAL_CYC = 4946;
   localparam int AZ_CYC = 78;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ACQ = 3'b001,
      ST_CONV = 3'b011,
      ST_DONE = 3'b010,
      ST_BUSY = 3'b110,
      ST_SLEEP = 3'b111,
      ST_WAKE = 3'b101,
      ST_TEST = 3'b100
   } ahp_state_e;
endpackage

// >>> ahp_delay.sv
// programmable down-counter used to time the converter phases
`timescale 1ns/1ns
`default_nettype none
module ahp_delay #(
   parameter int W = 20
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic load,
   input wire logic [W-1:0] count,
   output logic done
);
   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;
   logic done_ff;
   logic nxt_done;
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_done = 1'b0;
      if (load) begin
         nxt_cnt = count;
      end else if (cnt_ff != '0) begin
         nxt_cnt = cnt_ff - 1'b1;
         nxt_done = (cnt_ff == {{(W-1){1'b0}}, 1'b1});
      end
   end
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_ff <= '0;
         done_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         done_ff <= nxt_done;
      end
   end
   assign done = done_ff;
endmodule
`default_nettype wire

// >>> ahp_port.sv
// host command port: configuration capture, ready, low-power flag and sync handling
// Notes on behaviour
// - with latch_edge_select high, ready goes high within 65 ns of write.
// - ready goes high within 38 ns after read strobe rises ending a read.
// - standby write with latch_edge_select low drops low_power_flag within 230 ns.
// - reset write with latch_edge_select low raises low_power_flag within 45 ns.
// - after reset command, ready goes low within 2.5 ms.
// - standby, auto-cal or auto-zero writes deassert ready.
// - reads without writes keep converting the last written channel.
// - undefined command codes keep the command field, state and ready, but still load the channel and other config bits.
// - test mode ends only with sys_rst; no command leaves it.
// - sync bit clear: sync pin is an output, high while converting.
// - sync bit set: sync pin rising edge holds input and starts conversion.
`timescale 1ns/1ns
`default_nettype none
module ahp_port
   import ahp_pkg::*;
#(
   parameter int WAKE_RDY_CYCLES = WAKE_RDY_CYC,
   parameter int CAL_CYCLES = CAL_CYC
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic latch_edge_select,
   input wire logic [12:0] data_in,
   input wire logic [12:0] result_in,
   output logic [12:0] data_out,
   output logic data_oe,
   output logic ready_n,
   output logic low_power_flag,
   input wire logic sync_in,
   output logic sync_out,
   output logic sync_oe,
   output logic [3:0] mux_sel,
   output logic sample_hold,
   output logic test_mode
);
   localparam int DW = 22;
   ahp_state_e st_ff, nxt_st;
   logic [12:0] cfg_ff, nxt_cfg;
   logic [12:0] dout_ff, nxt_dout;
   logic doe_ff, nxt_doe;
   logic rdy_n_ff, nxt_rdy_n;
   logic lpf_ff, nxt_lpf;
   logic sync_o_ff, nxt_sync_o;
   logic sync_oe_ff, nxt_sync_oe;
   logic hold_ff, nxt_hold;
   logic test_ff, nxt_test;
   logic wr_q_ff, rd_q_ff, sync_q_ff;
   logic wr_ok_ff, nxt_wr_ok;
   logic rd_ok_ff, nxt_rd_ok;
   logic [3:0] mux_ff, nxt_mux;
   logic wr_evt, rd_end, sync_rise, ld;
   logic [DW-1:0] ld_cnt;
   logic tmr_done;
   logic [12:0] wr_word;
   logic [2:0] cmd;

   // strobe qualified only if cs stayed low since the strobe's falling edge
   always_comb begin
      nxt_wr_ok = wr_ok_ff;
      nxt_rd_ok = rd_ok_ff;
      if (wr_q_ff && !wr_n) begin
         nxt_wr_ok = !cs_n;
      end else if (cs_n) begin
         nxt_wr_ok = 1'b0;
      end
      if (rd_q_ff && !rd_n) begin
         nxt_rd_ok = !cs_n;
      end else if (cs_n) begin
         nxt_rd_ok = 1'b0;
      end
   end

   // active write edge: falling when latch_edge_select high, else rising
   always_comb begin
      if (latch_edge_select) begin
         wr_evt = wr_q_ff && !wr_n && !cs_n;
      end else begin
         wr_evt = !wr_q_ff && wr_n && wr_ok_ff && !cs_n;
      end
      rd_end = !rd_q_ff && rd_n && rd_ok_ff && !cs_n;
      sync_rise = !sync_q_ff && sync_in && cfg_ff[SYNC_BIT];
   end

   // 8-bit bus: high byte write lands in upper bits and clears hb
   always_comb begin
      wr_word = data_in;
      if (!cfg_ff[BW_BIT] && !data_in[BW_BIT]) begin
         if (cfg_ff[HB_BIT]) begin
            wr_word = {data_in[4:0], cfg_ff[7:0]};
            wr_word[HB_BIT] = 1'b0;
         end else begin
            wr_word = {cfg_ff[12:8], data_in[7:0]};
         end
      end
      cmd = wr_word[CMD_LSB +: 3];
   end

   always_comb begin
      nxt_st = st_ff;
      nxt_cfg = cfg_ff;
      nxt_rdy_n = rdy_n_ff;
      nxt_lpf = lpf_ff;
      nxt_hold = 1'b0;
      nxt_test = test_ff;
      nxt_mux = mux_ff;
      nxt_sync_o = sync_o_ff;
      nxt_dout = dout_ff;
      nxt_doe = !cs_n && !rd_n;
      ld = 1'b0;
      ld_cnt = '0;
      if (!cs_n && !rd_n) begin
         nxt_dout = result_in;
      end
      case (st_ff)
         ST_TEST: begin
            nxt_st = ST_TEST;
         end
         default: begin
            if (wr_evt && !rd_n && (cmd == CMD_TEST_A || cmd == CMD_TEST_B)) begin
               nxt_st = ST_TEST;
               nxt_test = 1'b1;
            end else if (wr_evt) begin
               nxt_cfg = wr_word;
               nxt_mux = wr_word[MUX_LSB +: MUX_W];
               nxt_rdy_n = 1'b1;
               case (cmd)
                  CMD_STANDBY: begin
                     nxt_rdy_n = 1'b1;
                     ld = 1'b1;
                     // trimmed by event, counter and flag latency so the flag meets its bound
                     ld_cnt = DW'(STBY_CYC - 3);
                     nxt_st = ST_SLEEP;
                  end
                  CMD_RESET: begin
                     ld = 1'b1;
                     ld_cnt = DW'(WAKE_RDY_CYCLES - 3);
                     nxt_lpf = 1'b1;
                     nxt_st = ST_WAKE;
                  end
                  CMD_AUTOCAL: begin
                     ld = 1'b1;
                     ld_cnt = DW'(CAL_CYCLES);
                     nxt_st = ST_BUSY;
                  end
                  CMD_AUTOZERO: begin
                     ld = 1'b1;
                     ld_cnt = DW'(AZ_CYC);
                     nxt_st = ST_BUSY;
                  end
                  CMD_NORMAL: begin
                     if (st_ff != ST_SLEEP) begin
                        nxt_st = ST_ACQ;
                     end
                  end
                  default: begin
                     nxt_cfg[CMD_LSB +: 3] = cfg_ff[CMD_LSB +: 3];
                     nxt_rdy_n = rdy_n_ff;
                  end
               endcase
            end else begin
               if (rd_end) begin
                  nxt_rdy_n = 1'b1;
               end
               case (st_ff)
                  ST_IDLE, ST_DONE: begin
                     if (rd_end && !cfg_ff[SYNC_BIT]) begin
                        nxt_st = ST_ACQ;
                     end else if (sync_rise) begin
                        nxt_st = ST_ACQ;
                     end
                  end
                  ST_ACQ: begin
                     nxt_hold = 1'b1;
                     ld = 1'b1;
                     ld_cnt = DW'(CONV_CYC);
                     nxt_st = ST_CONV;
                  end
                  ST_CONV, ST_BUSY, ST_WAKE: begin
                     if (tmr_done) begin
                        nxt_rdy_n = 1'b0;
                        nxt_st = ST_DONE;
                     end
                  end
                  ST_SLEEP: begin
                     if (tmr_done) begin
                        nxt_lpf = 1'b0;
                     end
                  end
                  default: begin
                     nxt_st = ST_IDLE;
                  end
               endcase
            end
         end
      endcase
      nxt_sync_o = (nxt_st == ST_CONV);
      nxt_sync_oe = !nxt_cfg[SYNC_BIT];
   end

   ahp_delay #(.W(DW)) ahp_delay_inst (
      .clock(clock),
      .sys_rst(sys_rst),
      .load(ld),
      .count(ld_cnt),
      .done(tmr_done)
   );

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         st_ff <= ST_IDLE;
         cfg_ff <= CFG_RESET;
         dout_ff <= '0;
         doe_ff <= 1'b0;
         rdy_n_ff <= 1'b1;
         lpf_ff <= 1'b1;
         sync_o_ff <= 1'b0;
         sync_oe_ff <= 1'b0;
         hold_ff <= 1'b0;
         test_ff <= 1'b0;
         wr_q_ff <= 1'b1;
         rd_q_ff <= 1'b1;
         sync_q_ff <= 1'b0;
         wr_ok_ff <= 1'b0;
         rd_ok_ff <= 1'b0;
         mux_ff <= '0;
      end else begin
         st_ff <= nxt_st;
         cfg_ff <= nxt_cfg;
         dout_ff <= nxt_dout;
         doe_ff <= nxt_doe;
         rdy_n_ff <= nxt_rdy_n;
         lpf_ff <= nxt_lpf;
         sync_o_ff <= nxt_sync_o;
         sync_oe_ff <= nxt_sync_oe;
         hold_ff <= nxt_hold;
         test_ff <= nxt_test;
         wr_q_ff <= wr_n;
         rd_q_ff <= rd_n;
         sync_q_ff <= sync_in;
         wr_ok_ff <= nxt_wr_ok;
         rd_ok_ff <= nxt_rd_ok;
         mux_ff <= nxt_mux;
      end
   end

   assign data_out = dout_ff;
   assign data_oe = doe_ff;
   assign ready_n = rdy_n_ff;
   assign low_power_flag = lpf_ff;
   assign sync_out = sync_o_ff;
   // sync pin driven only in sync-out mode
   assign sync_oe = sync_oe_ff;
   assign mux_sel = mux_ff;
   assign sample_hold = hold_ff;
   assign test_mode = test_ff;
endmodule
`default_nettype wire

// >>> ahp_port_assertions.sv
// checker for the host command port
`timescale 1ns/1ns
`default_nettype none
module ahp_port_assertions
   import ahp_pkg::*;
#(
   parameter int WAKE_RDY_CYCLES = WAKE_RDY_CYC
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic latch_edge_select,
   input wire logic [12:0] data_in,
   input wire logic ready_n,
   input wire logic low_power_flag,
   input wire logic [3:0] mux_sel,
   input wire logic test_mode
);
   logic wr_q_ff, nxt_wr_q, wev, full;
   logic [2:0] cmd;
   int wake_ff, nxt_wake;
   assign cmd = data_in[11:9];
   // write taken on the strobe edge that latch_edge_select picks
   assign wev = !cs_n && (latch_edge_select ? wr_q_ff && !wr_n : !wr_q_ff && wr_n);
   assign full = wev && data_in[12] && !test_mode;
   // counts from a reset command until ready drops; idle at zero otherwise
   always_comb begin
      nxt_wr_q = wr_n;
      nxt_wake = (wake_ff != 0 && ready_n) ? wake_ff + 1 : 0;
      if (full && cmd == CMD_RESET)
         nxt_wake = 1;
   end
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         wr_q_ff <= 1'b1;
         wake_ff <= 0;
      end else begin
         wr_q_ff <= nxt_wr_q;
         wake_ff <= nxt_wake;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // test and undefined codes leave ready alone, so only defined commands are held to the bound
   wr_ready_a: assert property (
      full && latch_edge_select && cmd <= CMD_STANDBY |-> ##[1:15] ready_n) else $error("ready late after write");
   rd_ready_a: assert property (
      $rose(rd_n) && !cs_n && !test_mode |-> ##[1:8] ready_n) else $error("ready late after read");
   stby_flag_a: assert property (
      full && !latch_edge_select && cmd == CMD_STANDBY |-> ##[1:56] !low_power_flag) else $error("standby late");
   wake_flag_a: assert property (
      full && !latch_edge_select && cmd == CMD_RESET |-> ##[1:10] low_power_flag) else $error("wake late");
   wake_ready_a: assert property (wake_ff <= WAKE_RDY_CYCLES) else $error("ready late after reset");
   mux_hold_a: assert property (
      $changed(mux_sel) |-> $past(wev) || $past(wev, 2) || $past(wev, 3)) else $error("channel moved");
   undef_cmd_a: assert property (
      full && cmd == 3'h7 && !ready_n |-> !ready_n [*6]) else $error("undefined code acted");
   test_stay_a: assert property (test_mode |=> test_mode) else $error("test mode left");
endmodule
bind ahp_port ahp_port_assertions #(.WAKE_RDY_CYCLES(WAKE_RDY_CYCLES)) ahp_port_assertions_inst (
   .clock(clock), .sys_rst(sys_rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
   .latch_edge_select(latch_edge_select), .data_in(data_in), .ready_n(ready_n),
   .low_power_flag(low_power_flag), .mux_sel(mux_sel), .test_mode(test_mode));
`default_nettype wire

// >>> ahp_host_model.sv
// host bus model: write and read cycles on the strobe pins
`timescale 1ns/1ns
`default_nettype none
module ahp_host_model (
   input wire logic clock,
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic [12:0] data_in
);
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      data_in = 13'h0000;
   end
   // chip select wraps the whole strobe
   task automatic wr(input logic [12:0] w, input logic cs_v, input logic rd_v);
      @(posedge clock);
      cs_n <= cs_v;
      rd_n <= rd_v;
      data_in <= w;
      @(posedge clock);
      wr_n <= 1'b0;
      repeat (2) @(posedge clock);
      wr_n <= 1'b1;
      @(posedge clock);
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      // released data lines show the inverse, not a stale copy
      data_in <= ~w;
      @(negedge clock);
   endtask
   task automatic rd();
      @(posedge clock);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      repeat (2) @(posedge clock);
      rd_n <= 1'b1;
      @(posedge clock);
      cs_n <= 1'b1;
      @(negedge clock);
   endtask
endmodule
`default_nettype wire

// >>> adc_host_command_port_test.sv
// bench for the host command port
`timescale 1ns/1ns
`default_nettype none
module adc_host_command_port_test
   import ahp_pkg::*;
;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic latch_edge_select = 1'b1;
   logic sync_in = 1'b0;
   logic cs_n, rd_n, wr_n, ready_n, low_power_flag, test_mode, data_oe, sync_out, sync_oe, sample_hold;
   logic [12:0] data_in, data_out;
   logic [3:0] mux_sel;
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;
   initial forever #2 clock = ~clock;
   ahp_host_model host_inst (.clock(clock), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in));
   ahp_port #(.WAKE_RDY_CYCLES(50), .CAL_CYCLES(30)) ahp_port_inst (.clock(clock), .sys_rst(sys_rst),
      .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .latch_edge_select(latch_edge_select), .data_in(data_in),
      .result_in(13'h0a5c), .data_out(data_out), .data_oe(data_oe), .ready_n(ready_n),
      .low_power_flag(low_power_flag), .sync_in(sync_in), .sync_out(sync_out), .sync_oe(sync_oe),
      .mux_sel(mux_sel), .sample_hold(sample_hold), .test_mode(test_mode));
   function automatic logic [12:0] w13(input logic [2:0] c, input logic [3:0] m);
      return {1'b1, c, 5'h00, m};
   endfunction
   task automatic check(input logic [12:0] got, input logic [12:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wait_for(input bit sel, input logic v, input int n);
      int i;
      for (i = 0; i < n && (sel ? low_power_flag : ready_n) !== v; i++)
         @(negedge clock);
      check(sel ? low_power_flag : ready_n, v);
   endtask
   task automatic do_reset();
      @(posedge clock);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (2) @(negedge clock);
   endtask
   // upper byte copied to both lanes so the byte lane choice cannot matter
   task automatic cfg13();
      host_inst.wr(13'h0085, 1'b0, 1'b1);
      wait_for(0, 1'b0, 300);
      host_inst.wr(13'h1010, 1'b0, 1'b1);
      wait_for(0, 1'b0, 300);
   endtask
   // sync-in mode is the reset state, so a rising sync pin alone starts a conversion
   task automatic t_sync();
      check(sync_oe, 1'b0);
      @(posedge clock);
      sync_in <= 1'b1;
      repeat (3) @(negedge clock);
      check(sample_hold, 1'b1);
      @(negedge clock);
      check(sample_hold, 1'b0);
      @(posedge clock);
      sync_in <= 1'b0;
      wait_for(0, 1'b0, 60);
   endtask
   task automatic t_write_read();
      host_inst.wr(w13(CMD_NORMAL, 4'h6), 1'b0, 1'b1);
      check(ready_n, 1'b1);
      check(sync_oe, 1'b1);
      check(sync_out, 1'b1);
      wait_for(0, 1'b0, 200);
      check(sync_out, 1'b0);
      repeat (2) begin
         host_inst.rd();
         wait_for(0, 1'b1, 8);
         check(data_out, 13'h0a5c);
         check(data_oe, 1'b0);
         wait_for(0, 1'b0, 200);
         check(mux_sel, 4'h6);
      end
      host_inst.wr(w13(CMD_NORMAL, 4'h9), 1'b1, 1'b1);
      check(mux_sel, 4'h6);
      host_inst.wr(w13(3'h7, 4'h9), 1'b0, 1'b1);
      check(ready_n, 1'b0);
      check(mux_sel, 4'h9);
   endtask
   task automatic t_cmds();
      logic [2:0] cmds [2] = '{CMD_AUTOCAL, CMD_AUTOZERO};
      foreach (cmds[i]) begin
         host_inst.wr(w13(cmds[i], 4'h6), 1'b0, 1'b1);
         check(ready_n, 1'b1);
         wait_for(0, 1'b0, 300);
      end
   endtask
   task automatic t_standby();
      @(posedge clock);
      latch_edge_select <= 1'b0;
      host_inst.wr(w13(CMD_STANDBY, 4'h6), 1'b0, 1'b1);
      wait_for(1, 1'b0, 56);
      check(ready_n, 1'b1);
      host_inst.wr(w13(CMD_RESET, 4'h6), 1'b0, 1'b1);
      wait_for(1, 1'b1, 10);
      wait_for(0, 1'b0, 49);
      @(posedge clock);
      latch_edge_select <= 1'b1;
   endtask
   // a wake period passes after the reset command to show it has no effect
   task automatic t_test();
      logic [2:0] codes [2] = '{CMD_TEST_A, CMD_TEST_B};
      foreach (codes[i]) begin
         do_reset();
         cfg13();
         host_inst.wr(w13(codes[i], 4'h3), 1'b0, 1'b0);
         check(test_mode, 1'b1);
         host_inst.wr(w13(CMD_RESET, 4'h3), 1'b0, 1'b1);
         repeat (60) @(negedge clock);
         check(test_mode, 1'b1);
      end
   endtask
   task automatic print_verdict();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 10000) begin
         num_errors++;
         print_verdict();
      end
   end
   initial begin
      do_reset();
      t_sync();
      cfg13();
      t_write_read();
      t_cmds();
      t_standby();
      t_test();
      print_verdict();
   end
endmodule
`default_nettype wire
